// [rtl/vhpc_consts.vh]
// Constants of the valve head indication and pulse clean block
//
// Behaviour
// - Target inside a band lights its colour; dark between bands. Code flashes red between bands in fault mode, and white after a clean.
// - Automatic setup only when all prerequisites hold, else retrofit setup forced.
// - Feedback defaults to de-energized/energized convention.
// - Valve-state output high while head and valve idle without fault, in automatic setup only; code also holds it high out of ST_IDLE, valve moving or not.
// - One-solenoid head offers pulse clean by default with no setup.
// - Pulse clean only on fieldbus variants with one solenoid, not discrete.
// - On reaching commanded position, pulse air released, valve returns.
// - After completion, requests ignored for 2 s, then re-armed.
// - Completion gives 2 s feedback pulse and visual indication.
`ifndef VHPC_CONSTS_VH
`define VHPC_CONSTS_VH

// ----------------------------------------------------------------
// Bus map
// ----------------------------------------------------------------
`define VHPC_ADDR_W 8
`define VHPC_REG_CTRL 8'h00
`define VHPC_REG_STATUS 8'h04
`define VHPC_REG_IRQ_STAT 8'h08
`define VHPC_REG_IRQ_MASK 8'h0C
`define VHPC_REG_BANDS 8'h10
`define VHPC_RESP_OKAY 2'b00
`define VHPC_RESP_SLVERR 2'b10

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define VHPC_CTRL_MODE_LO 0
`define VHPC_CTRL_MODE_HI 1
`define VHPC_CTRL_AUTOREQ 2
`define VHPC_CTRL_OPENCLOSED 3
`define VHPC_CTRL_RST 32'h0000_0004

// ----------------------------------------------------------------
// Modes and colours
// ----------------------------------------------------------------
`define VHPC_MODE_FACTORY 2'h0
`define VHPC_MODE_OPER 2'h1
`define VHPC_MODE_FAULT 2'h2
`define VHPC_COL_OFF 3'h0
`define VHPC_COL_GREEN 3'h1
`define VHPC_COL_WHITE 3'h2
`define VHPC_COL_BLUE 3'h3
`define VHPC_COL_YELLOW 3'h4
`define VHPC_COL_RED 3'h5
`define VHPC_BAND_NONE 3'h0
`define VHPC_BAND_DEEN 3'h1
`define VHPC_BAND_OPEN 3'h2
`define VHPC_BAND_UPPER 3'h3
`define VHPC_BAND_LOWER 3'h4

// ----------------------------------------------------------------
// Timing at 40 MHz
// ----------------------------------------------------------------
`define VHPC_CLK_HZ 40000000
`define VHPC_MIN_CMD_MS 500
`define VHPC_HOLD_MS 2000
`define VHPC_BLINK_MS 250
`define VHPC_MS_CYC(ms) ((ms) * (`VHPC_CLK_HZ / 1000))
`define VHPC_CNT_W 27

// ----------------------------------------------------------------
// Interrupt bits
// ----------------------------------------------------------------
`define VHPC_IRQ_ACCEPT 0
`define VHPC_IRQ_DONE 1
`define VHPC_IRQ_REARM 2
`define VHPC_IRQ_W 3

`endif

// [rtl/vhpc_led.v]
// Ring indicator colour mapping of the valve head
`timescale 1ns/10ps
`default_nettype none
`include "vhpc_consts.vh"

module vhpc_led #(
    parameter BLINK_CYC = `VHPC_MS_CYC(`VHPC_BLINK_MS)
) (
    // Clock and reset
    input wire clk,
    input wire nrst,
    input wire ce,
    // Inputs
    input wire [1:0] mode,
    input wire [2:0] band,
    input wire done_flash,
    // Output
    output reg [2:0] colour
);

// ----------------------------------------------------------------
// Blink timer
// ----------------------------------------------------------------
reg [`VHPC_CNT_W-1:0] tick;
reg phase;
reg [2:0] next_colour;
reg [2:0] base;

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        tick <= {`VHPC_CNT_W{1'b0}};
        phase <= 1'b0;
    end else if (ce) begin
        if (tick >= BLINK_CYC - 1) begin
            tick <= {`VHPC_CNT_W{1'b0}};
            phase <= ~phase;
        end else begin
            tick <= tick + 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// Colour selection
// ----------------------------------------------------------------
always @* begin
    case (band)
        `VHPC_BAND_DEEN: base = `VHPC_COL_GREEN;
        `VHPC_BAND_OPEN: base = `VHPC_COL_WHITE;
        `VHPC_BAND_UPPER: base = `VHPC_COL_BLUE;
        `VHPC_BAND_LOWER: base = `VHPC_COL_YELLOW;
        default: base = `VHPC_COL_OFF;
    endcase
    next_colour = base;
    if (done_flash) begin
        next_colour = phase ? `VHPC_COL_WHITE : `VHPC_COL_OFF;
    end else if (mode == `VHPC_MODE_FACTORY) begin
        next_colour = phase ? base : `VHPC_COL_OFF;
    end else if (mode == `VHPC_MODE_FAULT) begin
        if (base == `VHPC_COL_OFF)
            next_colour = phase ? `VHPC_COL_RED : `VHPC_COL_OFF;
        else
            next_colour = phase ? base : `VHPC_COL_RED;
    end
end

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        colour <= `VHPC_COL_OFF;
    end else if (ce) begin
        colour <= next_colour;
    end
end

endmodule // vhpc_led
`default_nettype wire

// [rtl/vhpc_top.v]
// Valve head indication and pulse seat clean controller
`timescale 1ns/10ps
`default_nettype none
`include "vhpc_consts.vh"

module vhpc_top #(
    parameter MIN_CMD_CYC = `VHPC_MS_CYC(`VHPC_MIN_CMD_MS),
    parameter HOLD_CYC = `VHPC_MS_CYC(`VHPC_HOLD_MS),
    parameter BLINK_CYC = `VHPC_MS_CYC(`VHPC_BLINK_MS)
) (
    // Clock, reset, enable
    input wire clk,
    input wire nrst,
    input wire ce,
    // AXI4-Lite write
    input wire [`VHPC_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [`VHPC_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Head configuration
    input wire fieldbus_variant,
    input wire [1:0] solenoid_count,
    input wire setup_prereq_ok,
    // Sensing
    input wire [2:0] target_band,
    input wire fault_present,
    input wire valve_moving,
    input wire pos_reached,
    // PLC link
    input wire pulse_cmd,
    output reg pilot_solenoid,
    output reg clean_done,
    output reg valve_state,
    output reg status_error,
    // Indication and interrupt
    output reg [2:0] led_colour,
    output reg irq
);

// ----------------------------------------------------------------
// Sequencer states
// ----------------------------------------------------------------
localparam ST_IDLE = 4'b0001;
localparam ST_PULSE = 4'b0010;
localparam ST_RETURN = 4'b0100;
localparam ST_HOLD = 4'b1000;

function wen_byte;
    input [3:0] strb;
    input integer bit_pos;
    begin
        wen_byte = strb[bit_pos / 8];
    end
endfunction

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg [31:0] ctrl;
reg [`VHPC_IRQ_W-1:0] irq_stat;
reg [`VHPC_IRQ_W-1:0] irq_mask;
reg [3:0] state;
reg [3:0] next_state;
reg [`VHPC_CNT_W-1:0] cmd_cnt;
reg [`VHPC_CNT_W-1:0] hold_cnt;
reg cmd_armed;
reg [`VHPC_IRQ_W-1:0] ev;
reg have_aw;
reg have_w;
reg [`VHPC_ADDR_W-1:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
wire [1:0] mode;
wire auto_setup;
wire clean_avail;
wire [2:0] led_next;

assign mode = ctrl[`VHPC_CTRL_MODE_HI:`VHPC_CTRL_MODE_LO];
// Auto setup only with every prerequisite met
assign auto_setup = ctrl[`VHPC_CTRL_AUTOREQ] & setup_prereq_ok;
// One solenoid, fieldbus only, no setup step
assign clean_avail = fieldbus_variant & (solenoid_count == 2'h1);

// ----------------------------------------------------------------
// AXI4-Lite slave
// ----------------------------------------------------------------
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `VHPC_RESP_OKAY;
        have_aw <= 1'b0;
        have_w <= 1'b0;
        aw_addr <= {`VHPC_ADDR_W{1'b0}};
        w_data <= 32'h0000_0000;
        w_strb <= 4'h0;
    end else if (ce) begin
        s_axi_awready <= !have_aw && !s_axi_awready && !s_axi_bvalid;
        s_axi_wready <= !have_w && !s_axi_wready && !s_axi_bvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            have_aw <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            have_w <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        if (have_aw && have_w && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            have_aw <= 1'b0;
            have_w <= 1'b0;
            case (aw_addr)
                `VHPC_REG_CTRL, `VHPC_REG_IRQ_MASK, `VHPC_REG_STATUS,
                `VHPC_REG_IRQ_STAT, `VHPC_REG_BANDS:
                    s_axi_bresp <= `VHPC_RESP_OKAY;
                default: s_axi_bresp <= `VHPC_RESP_SLVERR;
            endcase
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// Register writes
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        ctrl <= `VHPC_CTRL_RST;
        irq_mask <= {`VHPC_IRQ_W{1'b0}};
    end else if (ce && have_aw && have_w && !s_axi_bvalid) begin
        if (aw_addr == `VHPC_REG_CTRL && wen_byte(w_strb, 0))
            ctrl <= {28'h0000000, w_data[3:0]};
        if (aw_addr == `VHPC_REG_IRQ_MASK && wen_byte(w_strb, 0))
            irq_mask <= w_data[`VHPC_IRQ_W-1:0];
    end
end

// Read channel; interrupt status read clears sticky bits
wire rd_take = s_axi_arvalid && s_axi_arready;
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `VHPC_RESP_OKAY;
    end else if (ce) begin
        s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
        if (rd_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `VHPC_RESP_OKAY;
            case (s_axi_araddr)
                `VHPC_REG_CTRL: s_axi_rdata <= ctrl;
                `VHPC_REG_STATUS:
                    s_axi_rdata <= {22'h000000, auto_setup, clean_avail,
                        cmd_armed, valve_state, status_error, state, 1'b0};
                `VHPC_REG_IRQ_STAT:
                    s_axi_rdata <= {29'h00000000, irq_stat};
                `VHPC_REG_IRQ_MASK:
                    s_axi_rdata <= {29'h00000000, irq_mask};
                `VHPC_REG_BANDS:
                    s_axi_rdata <= {26'h0000000, led_colour, target_band};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `VHPC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// Pulse clean sequencer
// ----------------------------------------------------------------
always @* begin
    next_state = state;
    ev = {`VHPC_IRQ_W{1'b0}};
    case (state)
        ST_IDLE:
            if (cmd_armed && pulse_cmd && clean_avail
                && cmd_cnt >= MIN_CMD_CYC - 1) begin
                next_state = ST_PULSE;
                ev[`VHPC_IRQ_ACCEPT] = 1'b1;
            end
        ST_PULSE:
            if (pos_reached) begin
                next_state = ST_RETURN;
            end
        ST_RETURN:
            if (!pos_reached) begin
                next_state = ST_HOLD;
                ev[`VHPC_IRQ_DONE] = 1'b1;
            end
        ST_HOLD:
            if (hold_cnt >= HOLD_CYC - 1) begin
                next_state = ST_IDLE;
                ev[`VHPC_IRQ_REARM] = 1'b1;
            end
        default: next_state = ST_IDLE;
    endcase
end

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        state <= ST_IDLE;
        cmd_cnt <= {`VHPC_CNT_W{1'b0}};
        hold_cnt <= {`VHPC_CNT_W{1'b0}};
        cmd_armed <= 1'b1;
        pilot_solenoid <= 1'b0;
        clean_done <= 1'b0;
    end else if (ce) begin
        state <= next_state;
        // Command length counter
        if (pulse_cmd && state == ST_IDLE)
            cmd_cnt <= cmd_cnt + 1'b1;
        else
            cmd_cnt <= {`VHPC_CNT_W{1'b0}};
        // Held command must drop before a new cycle
        if (!pulse_cmd && state == ST_IDLE)
            cmd_armed <= 1'b1;
        else if (next_state == ST_PULSE)
            cmd_armed <= 1'b0;
        hold_cnt <= (state == ST_HOLD) ? hold_cnt + 1'b1
                                       : {`VHPC_CNT_W{1'b0}};
        pilot_solenoid <= (next_state == ST_PULSE);
        clean_done <= (next_state == ST_HOLD);
    end
end

// ----------------------------------------------------------------
// Status outputs
// ----------------------------------------------------------------
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        valve_state <= 1'b0;
        status_error <= 1'b0;
    end else if (ce) begin
        // Valve still, or sequencer out of ST_IDLE, without fault keeps valve state high in automatic setup only
        valve_state <= auto_setup && !fault_present
            && (!valve_moving || state != ST_IDLE);
        status_error <= !auto_setup && fault_present;
    end
end

// ----------------------------------------------------------------
// Interrupts
// ----------------------------------------------------------------
// Set wins over read clear
wire [`VHPC_IRQ_W-1:0] next_irq_stat;
assign next_irq_stat = (rd_take && s_axi_araddr == `VHPC_REG_IRQ_STAT)
    ? ev : (irq_stat | ev);

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        irq_stat <= {`VHPC_IRQ_W{1'b0}};
        irq <= 1'b0;
    end else if (ce) begin
        irq_stat <= next_irq_stat;
        irq <= |(next_irq_stat & irq_mask);
    end
end

// ----------------------------------------------------------------
// Indicator
// ----------------------------------------------------------------
vhpc_led #(
    .BLINK_CYC(BLINK_CYC)
) u_led (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .mode(mode),
    .band(target_band),
    .done_flash(clean_done),
    .colour(led_next)
);

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        led_colour <= `VHPC_COL_OFF;
    end else if (ce) begin
        led_colour <= led_next;
    end
end

endmodule // vhpc_top
`default_nettype wire

// [dv/vhpc_plc_model.sv]
// PLC and valve stand-in for pulse clean runs
`timescale 1ns/10ps
`default_nettype none
module vhpc_plc_model (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Bench request
    input wire logic [7:0] req_len,
    input wire logic req_go,
    // Head side
    input wire logic pilot_solenoid,
    output logic pulse_cmd,
    output logic pos_reached
);
    logic [7:0] left;
    logic [1:0] lag;
    assign pulse_cmd = left != 8'h00;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            left <= 8'h00;
            lag <= 2'h0;
            pos_reached <= 1'h0;
        end else begin
            if (req_go) left <= req_len;
            else if (left != 8'h00) left <= left - 8'h01;
            lag <= (pilot_solenoid != pos_reached) ? lag + 2'h1 : 2'h0;
            if (lag == 2'h3) pos_reached <= pilot_solenoid;
        end
    end
endmodule // vhpc_plc_model
`default_nettype wire

// [dv/vhpc_top_assertions.sv]
// Assertion checker of the pulse clean controller
`timescale 1ns/10ps
`default_nettype none
`include "vhpc_consts.vh"
module vhpc_top_assertions #(
    parameter MIN_CMD_CYC = 8,
    parameter HOLD_CYC = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Watched pins
    input wire logic pulse_cmd,
    input wire logic pos_reached,
    input wire logic pilot_solenoid,
    input wire logic clean_done,
    input wire logic fieldbus_variant,
    input wire logic [1:0] solenoid_count,
    input wire logic setup_prereq_ok,
    input wire logic fault_present,
    input wire logic valve_state,
    input wire logic [2:0] target_band,
    input wire logic [2:0] led_colour
);
    int cmd_n;
    int done_n;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmd_n <= 0;
            done_n <= 0;
        end else begin
            cmd_n <= pulse_cmd ? cmd_n + 1 : 0;
            done_n <= clean_done ? done_n + 1 : 0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence at_pos;
        pilot_solenoid && pos_reached;
    endsequence
    sequence dark_band;
        (target_band == `VHPC_BAND_NONE && !clean_done) [*6];
    endsequence
    pilot_min_a: assert property (
        $rose(pilot_solenoid) |-> $past(cmd_n) >= MIN_CMD_CYC - 1)
        else $error("pulse on short command");
    pilot_drop_a: assert property (
        at_pos |-> ##[1:2] !pilot_solenoid)
        else $error("pulse air held at position");
    done_len_a: assert property (
        $fell(clean_done) |-> done_n == HOLD_CYC)
        else $error("handshake length wrong");
    hold_quiet_a: assert property (
        clean_done |=> !$rose(pilot_solenoid))
        else $error("pulse during hold");
    variant_gate_a: assert property (
        $rose(pilot_solenoid) |->
        $past(fieldbus_variant) && $past(solenoid_count) == 2'h1)
        else $error("pulse on wrong variant");
    fault_vstate_a: assert property (
        fault_present [*4] |-> !valve_state)
        else $error("valve state high on fault");
    setup_vstate_a: assert property (
        !setup_prereq_ok [*4] |-> !valve_state)
        else $error("valve state high in retrofit");
    led_dark_a: assert property (
        dark_band |-> led_colour inside {`VHPC_COL_OFF, `VHPC_COL_RED})
        else $error("colour lit between bands");
endmodule // vhpc_top_assertions
bind vhpc_top vhpc_top_assertions #(
    .MIN_CMD_CYC(MIN_CMD_CYC),
    .HOLD_CYC(HOLD_CYC)
) chk_i (.*);
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench of the pulse clean controller
`timescale 1ns/10ps
`default_nettype none
`include "vhpc_consts.vh"
module testbench;
    localparam HOLD = 16;
    logic clk = 1'h0, nrst = 1'h0, ce = 1'h1, i0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic fieldbus_variant = 1'h1, setup_prereq_ok = 1'h1;
    logic [1:0] solenoid_count = 2'h1;
    logic [2:0] target_band = 3'h0;
    logic fault_present = 1'h0, valve_moving = 1'h0, req_go = 1'h0;
    logic [7:0] req_len = 8'h00;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire pulse_cmd, pos_reached, pilot_solenoid, clean_done;
    wire valve_state, status_error;
    wire [2:0] led_colour;
    int bad_count = 0, checked = 0, n_pulse = 0, done_run = 0, run = 0;
    logic p_d = 1'h0;
    vhpc_top #(.MIN_CMD_CYC(8), .HOLD_CYC(HOLD), .BLINK_CYC(4)) dut (.*);
    vhpc_plc_model plc (.*);
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        p_d <= pilot_solenoid;
        if (pilot_solenoid && !p_d) n_pulse++;
        run <= clean_done ? run + 1 : 0;
        if (!clean_done && run != 0) done_run <= run;
    end
    task tally_and_finish;
        $display("checks %0d errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, s);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk("bresp", `VHPC_RESP_OKAY, s_axi_bresp);
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        s_axi_rready <= 1'h0;
        if (a == 8'h20) chk("rresp", `VHPC_RESP_SLVERR, s_axi_rresp);
    endtask
    task go(input logic [7:0] n, input int w);
        @(posedge clk);
        req_len <= n;
        req_go <= 1'h1;
        @(posedge clk);
        req_go <= 1'h0;
        repeat (w) @(posedge clk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_regs;
        logic [31:0] d;
        rd(`VHPC_REG_CTRL, d);
        chk("ctrl reset", `VHPC_CTRL_RST, d);
        rd(8'h20, d);
        chk("unmapped data", 32'h0, d);
        rd(`VHPC_REG_STATUS, d);
        chk("status idle", 32'h0000_03C2, d);
        wr(`VHPC_REG_IRQ_MASK, 32'h7);
    endtask
    task t_clean;
        int n;
        logic [31:0] d;
        n = n_pulse;
        go(8'h0C, 60);
        chk("pulses", n + 1, n_pulse);
        chk("pilot back", 1'h0, pilot_solenoid);
        chk("done length", HOLD, done_run);
        i0 = irq;
        chk("irq set", 1'h1, i0);
        rd(`VHPC_REG_IRQ_STAT, d);
        chk("irq status", 32'h7, d);
        repeat (3) @(posedge clk);
        chk("irq level", 1'h0, irq);
        rd(`VHPC_REG_IRQ_STAT, d);
        chk("irq status clear", 32'h0, d);
    endtask
    task t_short;
        int n;
        n = n_pulse;
        go(8'h06, 30);
        chk("short command", n, n_pulse);
    endtask
    task t_hold;
        int n;
        wr(`VHPC_REG_IRQ_MASK, 32'h7);
        go(8'h0C, 0);
        while (clean_done !== 1'h1) @(posedge clk);
        n = n_pulse;
        go(8'h0C, 40);
        chk("held off", n, n_pulse);
        go(8'h0C, 60);
        chk("rearmed", n + 1, n_pulse);
        chk("irq mask", 1'h1, irq);
        wr(`VHPC_REG_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq masked", 1'h0, irq);
    endtask
    task t_variant;
        int n;
        n = n_pulse;
        fieldbus_variant <= 1'h0;
        go(8'h0C, 40);
        fieldbus_variant <= 1'h1;
        solenoid_count <= 2'h0;
        go(8'h0C, 40);
        solenoid_count <= 2'h1;
        chk("no clean", n, n_pulse);
    endtask
    task see(input logic [2:0] b, c1, c2);
        logic h1, h2;
        h1 = 1'h0;
        h2 = 1'h0;
        target_band <= b;
        repeat (8) @(posedge clk);
        repeat (30) begin
            @(posedge clk);
            if (led_colour === c1) h1 = 1'h1;
            if (led_colour === c2) h2 = 1'h1;
        end
        chk("flash colours", 2'h3, {h1, h2});
    endtask
    task t_led;
        logic [2:0] cols [5] = '{`VHPC_COL_OFF, `VHPC_COL_GREEN,
            `VHPC_COL_WHITE, `VHPC_COL_BLUE, `VHPC_COL_YELLOW};
        wr(`VHPC_REG_CTRL, 32'h5);
        for (int b = 0; b < 5; b++) begin
            target_band <= b[2:0];
            repeat (8) @(posedge clk);
            chk("steady colour", cols[b], led_colour);
        end
        wr(`VHPC_REG_CTRL, 32'h4);
        see(`VHPC_BAND_UPPER, `VHPC_COL_BLUE, `VHPC_COL_OFF);
        wr(`VHPC_REG_CTRL, 32'h6);
        see(`VHPC_BAND_OPEN, `VHPC_COL_WHITE, `VHPC_COL_RED);
        see(`VHPC_BAND_NONE, `VHPC_COL_RED, `VHPC_COL_OFF);
        wr(`VHPC_REG_CTRL, 32'h5);
    endtask
    task t_vstate;
        repeat (6) @(posedge clk);
        chk("idle state", 1'h1, valve_state);
        valve_moving <= 1'h1;
        repeat (6) @(posedge clk);
        chk("busy state", 1'h0, valve_state);
        valve_moving <= 1'h0;
        fault_present <= 1'h1;
        repeat (6) @(posedge clk);
        chk("fault state", 1'h0, valve_state);
        chk("auto error", 1'h0, status_error);
        setup_prereq_ok <= 1'h0;
        repeat (6) @(posedge clk);
        chk("retrofit error", 1'h1, status_error);
        fault_present <= 1'h0;
        setup_prereq_ok <= 1'h1;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'h1;
        t_regs();
        t_clean();
        t_short();
        t_hold();
        t_variant();
        t_led();
        t_vstate();
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
